// ---- common/btc_defs.vh ----
// register offsets, field positions, reset values and codes of the bridge register bank
`ifndef BTC_DEFS_VH
`define BTC_DEFS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define BTC_OFS_RETRY      8'h78
`define BTC_OFS_MTO        8'h80
`define BTC_OFS_SLOT       8'hb0
`define BTC_OFS_PMCAP      8'hdc
`define BTC_OFS_PMCSR      8'he0
`define BTC_OFS_HSCAP      8'he4
`define BTC_OFS_CTRL       8'hf0
`define BTC_OFS_IRQ_STAT   8'hf4
`define BTC_OFS_IRQ_MASK   8'hf8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define BTC_RETRY_RST      32'h01000000
`define BTC_MTO_RST        16'h8000

// ----------------------------------------------------------------------
// capability codes and links
// ----------------------------------------------------------------------
`define BTC_CAP_PM         8'h01
`define BTC_CAP_SLOT       8'h04
`define BTC_CAP_HS         8'h06
`define BTC_PM_NEXT        8'h0b
`define BTC_SLOT_NEXT_HS   8'hc0
`define BTC_NEXT_END       8'h00
`define BTC_PM_REV         3'h1

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BTC_SLOT_NUM_LSB   16
`define BTC_SLOT_NUM_MSB   20
`define BTC_SLOT_FIRST_BIT 21
`define BTC_CHASSIS_LSB    24
`define BTC_CHASSIS_MSB    31
`define BTC_PM_REV_LSB     16
`define BTC_PM_REV_MSB     18

// ----------------------------------------------------------------------
// power state codes
// ----------------------------------------------------------------------
`define BTC_PS_D0          2'h0
`define BTC_PS_D3          2'h3

// ----------------------------------------------------------------------
// status bit positions (interrupt status and mask)
// ----------------------------------------------------------------------
`define BTC_ST_RETRY       0
`define BTC_ST_PTO         1
`define BTC_ST_STO         2
`define BTC_ST_DWND        3
`define BTC_ST_W           4

// ----------------------------------------------------------------------
// control word bit positions
// ----------------------------------------------------------------------
`define BTC_CT_RETRY_START 0
`define BTC_CT_RETRY_DONE  1
`define BTC_CT_PTO_START   2
`define BTC_CT_STO_START   3

// internal reset pulse length in clocks
`define BTC_CHIP_RST_CYC   4'h8

`endif

// ---- hdl/btc_regs.v ----
// register bank with retry/master timeout counters and capability list
`timescale 1ns/10ps
`include "btc_defs.vh"

module btc_regs (
  input  wire        clk_i,        // primary bus clock
  input  wire        rst_i,        // synchronous reset, active high
  input  wire [7:0]  wb_adr_i,     // byte address
  input  wire [31:0] wb_dat_i,     // write data
  input  wire [3:0]  wb_sel_i,     // byte enables
  input  wire        wb_we_i,      // write
  input  wire        wb_cyc_i,     // cycle
  input  wire        wb_stb_i,     // strobe
  output reg  [31:0] wb_dat_o,     // read data
  output reg         wb_ack_o,     // acknowledge
  input  wire        hot_swap_enable_strap_i, // strap pin
  input  wire        retry_attempt_i,  // pulse: one delivery attempt made
  input  wire        pri_tick_i,       // primary bus clock tick
  input  wire        sec_tick_i,       // secondary bus clock tick
  output reg         retry_expired_o,  // pulse: retry limit reached
  output reg         pri_timeout_o,    // pulse: primary timeout
  output reg         sec_timeout_o,    // pulse: secondary timeout
  output reg         chip_reset_o,     // internal chip reset, active high
  output reg         primary_system_error_n_o, // system error, active low
  output reg         irq_o             // level interrupt
);

  // --------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------
  reg [3:0] s1_q;
  reg [3:0] s2_q;
  reg       pri_prev_q;
  reg       sec_prev_q;
  reg       att_prev_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      pri_prev_q <= 1'b0;
      sec_prev_q <= 1'b0;
      att_prev_q <= 1'b0;
    end else begin
      s1_q <= {hot_swap_enable_strap_i, sec_tick_i, pri_tick_i,
               retry_attempt_i};
      s2_q <= s1_q;
      pri_prev_q <= s2_q[1];
      sec_prev_q <= s2_q[2];
      att_prev_q <= s2_q[0];
    end
  end
  wire strap_s   = s2_q[3];
  wire attempt_e = s2_q[0] & ~att_prev_q;
  wire pri_e     = s2_q[1] & ~pri_prev_q;
  wire sec_e     = s2_q[2] & ~sec_prev_q;

  // --------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------
  wire req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr   = req & wb_we_i;
  wire rd   = req & ~wb_we_i;
  wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire w_retry = wr & (wb_adr_i == `BTC_OFS_RETRY);
  wire w_mto   = wr & (wb_adr_i == `BTC_OFS_MTO);
  wire w_slot  = wr & (wb_adr_i == `BTC_OFS_SLOT);
  wire w_pmcsr = wr & (wb_adr_i == `BTC_OFS_PMCSR);
  wire w_ctrl  = wr & (wb_adr_i == `BTC_OFS_CTRL);
  wire w_mask  = wr & (wb_adr_i == `BTC_OFS_IRQ_MASK);
  wire r_stat  = rd & (wb_adr_i == `BTC_OFS_IRQ_STAT);

  // --------------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------------
  reg [31:0] retry_limit_q;
  reg [15:0] pri_mto_q;
  reg [15:0] sec_mto_q;
  reg [4:0]  slot_num_q;
  reg        first_chassis_q;
  reg [7:0]  chassis_q;
  reg [1:0]  pstate_q;
  reg [`BTC_ST_W-1:0] mask_q;
  reg        d3_to_d0_q;

  wire [31:0] retry_nx  = (retry_limit_q & ~bmask) | (wb_dat_i & bmask);
  wire [31:0] mto_cur   = {sec_mto_q, pri_mto_q};
  wire [31:0] mto_nx    = (mto_cur & ~bmask) | (wb_dat_i & bmask);
  wire [1:0]  ps_wdat   = wb_dat_i[1:0];
  wire ps_legal = (ps_wdat == `BTC_PS_D0) | (ps_wdat == `BTC_PS_D3);
  wire ps_write = w_pmcsr & wb_sel_i[0] & ps_legal;

  always @(posedge clk_i) begin
    if (rst_i || chip_reset_o) begin
      retry_limit_q   <= `BTC_RETRY_RST;
      pri_mto_q       <= `BTC_MTO_RST;
      sec_mto_q       <= `BTC_MTO_RST;
      slot_num_q      <= 5'h00;
      first_chassis_q <= 1'b0;
      chassis_q       <= 8'h00;
      pstate_q        <= `BTC_PS_D0;
      mask_q          <= {`BTC_ST_W{1'b0}};
      d3_to_d0_q      <= 1'b0;
    end else begin
      d3_to_d0_q <= 1'b0;
      if (w_retry)
        retry_limit_q <= retry_nx;
      if (w_mto) begin
        pri_mto_q <= mto_nx[15:0];
        sec_mto_q <= mto_nx[31:16];
      end
      if (w_slot && wb_sel_i[2]) begin
        slot_num_q <= wb_dat_i[`BTC_SLOT_NUM_MSB:`BTC_SLOT_NUM_LSB];
        first_chassis_q <= wb_dat_i[`BTC_SLOT_FIRST_BIT];
      end
      if (w_slot && wb_sel_i[3])
        chassis_q <= wb_dat_i[`BTC_CHASSIS_MSB:`BTC_CHASSIS_LSB];
      // unimplemented codes complete but are dropped
      if (ps_write) begin
        pstate_q <= ps_wdat;
        d3_to_d0_q <= (pstate_q == `BTC_PS_D3) &&
                      (ps_wdat == `BTC_PS_D0);
      end
      if (w_mask && wb_sel_i[0])
        mask_q <= wb_dat_i[`BTC_ST_W-1:0];
    end
  end

  // --------------------------------------------------------------------
  // internal chip reset pulse; secondary bus reset is never driven here
  // --------------------------------------------------------------------
  reg [3:0] crst_cnt_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      crst_cnt_q   <= 4'h0;
      chip_reset_o <= 1'b0;
    end else begin
      if (d3_to_d0_q) begin
        crst_cnt_q   <= `BTC_CHIP_RST_CYC;
        chip_reset_o <= 1'b1;
      end else if (crst_cnt_q != 4'h0) begin
        crst_cnt_q   <= crst_cnt_q - 4'h1;
        chip_reset_o <= (crst_cnt_q != 4'h1);
      end else begin
        chip_reset_o <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // counters: retry attempts and the two master timeouts
  // --------------------------------------------------------------------
  wire ctl_retry_start = w_ctrl & wb_sel_i[0] & wb_dat_i[`BTC_CT_RETRY_START];
  wire ctl_retry_done  = w_ctrl & wb_sel_i[0] & wb_dat_i[`BTC_CT_RETRY_DONE];
  wire ctl_pto_start   = w_ctrl & wb_sel_i[0] & wb_dat_i[`BTC_CT_PTO_START];
  wire ctl_sto_start   = w_ctrl & wb_sel_i[0] & wb_dat_i[`BTC_CT_STO_START];

  reg [31:0] retry_cnt_q;
  reg        retry_run_q;
  reg [15:0] pri_cnt_q;
  reg        pri_run_q;
  reg [15:0] sec_cnt_q;
  reg        sec_run_q;

  always @(posedge clk_i) begin
    if (rst_i || chip_reset_o) begin
      retry_cnt_q <= 32'h00000000;
      retry_run_q <= 1'b0;
      pri_cnt_q <= 16'h0000;
      pri_run_q <= 1'b0;
      sec_cnt_q <= 16'h0000;
      sec_run_q <= 1'b0;
      retry_expired_o <= 1'b0;
      pri_timeout_o <= 1'b0;
      sec_timeout_o <= 1'b0;
    end else begin
      retry_expired_o <= 1'b0;
      pri_timeout_o <= 1'b0;
      sec_timeout_o <= 1'b0;
      if (ctl_retry_start) begin
        retry_cnt_q <= retry_limit_q;
        retry_run_q <= 1'b1;
      end else if (ctl_retry_done) begin
        retry_run_q <= 1'b0;
      end else if (retry_run_q && attempt_e) begin
        if (retry_cnt_q <= 32'h00000001) begin
          retry_run_q <= 1'b0;
          retry_expired_o <= 1'b1;
        end
        retry_cnt_q <= retry_cnt_q - 32'h00000001;
      end
      if (ctl_pto_start) begin
        pri_cnt_q <= pri_mto_q;
        pri_run_q <= 1'b1;
      end else if (pri_run_q && pri_e) begin
        if (pri_cnt_q <= 16'h0001) begin
          pri_run_q <= 1'b0;
          pri_timeout_o <= 1'b1;
        end
        pri_cnt_q <= pri_cnt_q - 16'h0001;
      end
      if (ctl_sto_start) begin
        sec_cnt_q <= sec_mto_q;
        sec_run_q <= 1'b1;
      end else if (sec_run_q && sec_e) begin
        if (sec_cnt_q <= 16'h0001) begin
          sec_run_q <= 1'b0;
          sec_timeout_o <= 1'b1;
        end
        sec_cnt_q <= sec_cnt_q - 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------
  // sticky status, read-to-clear, mask and interrupt
  // --------------------------------------------------------------------
  reg  [`BTC_ST_W-1:0] stat_q;
  wire [`BTC_ST_W-1:0] ev;
  assign ev[`BTC_ST_RETRY] = retry_expired_o;
  assign ev[`BTC_ST_PTO]   = pri_timeout_o;
  assign ev[`BTC_ST_STO]   = sec_timeout_o;
  // delayed write non-delivery: retry limit hit on a running delayed write
  assign ev[`BTC_ST_DWND]  = retry_expired_o;

  genvar gi;
  generate
    for (gi = 0; gi < `BTC_ST_W; gi = gi + 1) begin : g_stat
      always @(posedge clk_i) begin
        if (rst_i || chip_reset_o)
          stat_q[gi] <= 1'b0;
        else if (ev[gi])
          stat_q[gi] <= 1'b1;               // set wins over read clear
        else if (r_stat)
          stat_q[gi] <= 1'b0;
      end
    end
  endgenerate

  always @(posedge clk_i) begin
    if (rst_i || chip_reset_o) begin
      irq_o <= 1'b0;
      primary_system_error_n_o <= 1'b1;
    end else begin
      irq_o <= |(stat_q & mask_q);
      primary_system_error_n_o <= ~stat_q[`BTC_ST_DWND];
    end
  end

  // --------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------
  reg [31:0] rdat;
  always @* begin
    rdat = 32'h00000000;
    case (wb_adr_i)
      `BTC_OFS_RETRY: rdat = retry_limit_q;
      `BTC_OFS_MTO:   rdat = {sec_mto_q, pri_mto_q};
      `BTC_OFS_SLOT: begin
        rdat[7:0]   = `BTC_CAP_SLOT;
        rdat[15:8]  = strap_s ? `BTC_SLOT_NEXT_HS
                              : `BTC_NEXT_END;
        rdat[`BTC_SLOT_NUM_MSB:`BTC_SLOT_NUM_LSB] = slot_num_q;
        rdat[`BTC_SLOT_FIRST_BIT] = first_chassis_q;
        rdat[`BTC_CHASSIS_MSB:`BTC_CHASSIS_LSB] = chassis_q;
        // bits 23:22 stay zero
      end
      `BTC_OFS_PMCAP: begin
        rdat[7:0]   = `BTC_CAP_PM;
        rdat[15:8]  = `BTC_PM_NEXT;
        rdat[`BTC_PM_REV_MSB:`BTC_PM_REV_LSB] = `BTC_PM_REV;
        // bits 31:19 stay zero, and
      end
      `BTC_OFS_PMCSR: rdat[1:0] = pstate_q;  // 15:2 zero
      `BTC_OFS_HSCAP: begin
        rdat[7:0]  = `BTC_CAP_HS;
        rdat[15:8] = `BTC_NEXT_END;
      end
      `BTC_OFS_CTRL: rdat[`BTC_CT_STO_START:0] =
        {sec_run_q, pri_run_q, 1'b0, retry_run_q};
      `BTC_OFS_IRQ_STAT: rdat[`BTC_ST_W-1:0] = stat_q;
      `BTC_OFS_IRQ_MASK: rdat[`BTC_ST_W-1:0] = mask_q;
      default: rdat = 32'h00000000;
    endcase
  end

  // --------------------------------------------------------------------
  // bus answer: one wait state, ack for every address
  // --------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= rd ? rdat : 32'h00000000;
    end
  end

endmodule

// ---- verification/btc_regs_properties.sv ----
// assertions on the ports of the bridge register bank
`timescale 1ns/10ps
module btc_regs_chk (
  input wire        clk_i,                    // clock
  input wire        rst_i,                    // sync reset
  input wire [7:0]  wb_adr_i,                 // address
  input wire        wb_we_i,                  // write
  input wire        wb_cyc_i,                 // cycle
  input wire        wb_stb_i,                 // strobe
  input wire [31:0] wb_dat_o,                 // read data
  input wire        wb_ack_o,                 // acknowledge
  input wire        retry_expired_o,          // retry expiry pulse
  input wire        primary_system_error_n_o, // system error
  input wire        chip_reset_o              // internal reset
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence s_rd(logic [7:0] a);
    wb_ack_o && !wb_we_i && wb_adr_i == a;
  endsequence
  // the pulse counter is loaded with eight, so the reset stands eight clocks
  sequence s_rst_run;
    chip_reset_o [*8] ##1 !chip_reset_o;
  endsequence

  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("no acknowledge one cycle after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside acknowledge");
  chk_slot_word: assert property (s_rd(8'hb0) |->
    wb_dat_o[7:0] == 8'h04 && wb_dat_o[23:22] == 2'h0 &&
    (wb_dat_o[15:8] == 8'hc0 || wb_dat_o[15:8] == 8'h00))
    else $error("slot capability word wrong");
  chk_pm_word: assert property (s_rd(8'hdc) |->
    wb_dat_o == 32'h00010b01) else $error("power capability word wrong");
  chk_state_word: assert property (s_rd(8'he0) |->
    wb_dat_o[15:2] == 14'h0) else $error("power state fixed bits set");
  chk_hs_word: assert property (s_rd(8'he4) |->
    wb_dat_o[15:0] == 16'h0006) else $error("hot swap word wrong");
  // status bit is set one clock after the pulse, the pin one clock later
  chk_error_out: assert property (retry_expired_o |->
    ##2 !primary_system_error_n_o) else $error("system error not raised");
  chk_rst_pulse: assert property ($rose(chip_reset_o) |->
    s_rst_run) else $error("internal reset pulse length wrong");
endmodule

bind btc_regs btc_regs_chk chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .retry_expired_o(retry_expired_o),
  .primary_system_error_n_o(primary_system_error_n_o),
  .chip_reset_o(chip_reset_o)
);

// ---- verification/btc_event_src.sv ----
// model of the forwarding engine that feeds attempts and bus ticks
`timescale 1ns/10ps
module btc_event_src (
  input  wire       clk_i, // bus clock
  output reg  [2:0] ev_o   // attempt, primary tick, secondary tick
);
  initial ev_o = 3'h0;
  // each event is a full high then low so the synchroniser sees one edge
  task automatic send(input logic [2:0] which, input int n, input int gap);
    repeat (n) begin
      @(posedge clk_i);
      ev_o <= which;
      repeat (2) @(posedge clk_i);
      ev_o <= 3'h0;
      repeat (gap + 1) @(posedge clk_i);
    end
  endtask
endmodule

// ---- verification/btc_regs_tb.sv ----
// self-checking bench for the bridge register bank
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module btc_regs_tb;
  logic        clk_i, rst_i, cyc, stb, we, strap;
  logic        ack, r_exp, p_to, s_to, c_rst, serr_n, irq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [2:0]  ev;
  logic [31:0] wdat, rdat, q;
  int          err_total = 0, checks = 0, n_r = 0, n_p = 0, n_s = 0;

  btc_event_src ev_src (.clk_i(clk_i), .ev_o(ev));
  btc_regs uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(rdat), .wb_ack_o(ack), .hot_swap_enable_strap_i(strap),
    .retry_attempt_i(ev[0]), .pri_tick_i(ev[1]), .sec_tick_i(ev[2]),
    .retry_expired_o(r_exp), .pri_timeout_o(p_to), .sec_timeout_o(s_to),
    .chip_reset_o(c_rst), .primary_system_error_n_o(serr_n), .irq_o(irq)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // count expiry pulses so a doubled pulse shows up
  always @(posedge clk_i) begin
    if (r_exp === 1'b1) n_r <= n_r + 1;
    if (p_to === 1'b1) n_p <= n_p + 1;
    if (s_to === 1'b1) n_s <= n_s + 1;
  end

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    adr  <= a;
    we   <= w;
    sel  <= s;
    wdat <= d;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    if (ack !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t no acknowledge", $time);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 4'hf, 32'h0);
    `CHK(q, e)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, 4'hf, d);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // whole run needs a few hundred clocks; this is ample margin
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    close_out();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h0;
    sel = 4'h0;
    wdat = 32'h0;
    strap = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK(serr_n, 1'b1)
    rd(8'h78, 32'h01000000);
    rd(8'h80, 32'h80008000);
    rd(8'hb0, 32'h0000c004);
    rd(8'hdc, 32'h00010b01);
    rd(8'he0, 32'h00000000);
    rd(8'he4, 32'h00000006);
    wr(8'hec, 32'hffffffff);
    rd(8'hec, 32'h00000000);
    wr(8'h78, 32'hffffffff);
    rd(8'h78, 32'hffffffff);
    xfer(8'h80, 1'b1, 4'h3, 32'h12345678);
    rd(8'h80, 32'h80005678);
    xfer(8'h80, 1'b1, 4'hc, 32'h12345678);
    rd(8'h80, 32'h12345678);
    wr(8'hb0, 32'hffffffff);
    rd(8'hb0, 32'hff3fc004);
    strap <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(8'hb0, 32'hff3f0004);
    wr(8'hdc, 32'hffffffff);
    rd(8'hdc, 32'h00010b01);
    // retry limit of two attempts, unmasked
    wr(8'h78, 32'h00000002);
    wr(8'hf8, 32'h0000000f);
    wr(8'hf0, 32'h00000001);
    rd(8'hf0, 32'h00000001);
    ev_src.send(3'h1, 2, 1);
    for (int i = 0; i < 200 && n_r < 1; i++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    `CHK(serr_n, 1'b0)
    `CHK(irq, 1'b1)
    ev_src.send(3'h1, 2, 0);
    `CHK(n_r, 1)
    rd(8'hf4, 32'h00000009);
    repeat (3) @(posedge clk_i);
    `CHK(serr_n, 1'b1)
    `CHK(irq, 1'b0)
    rd(8'hf4, 32'h00000000);
    // a delivered write stops the count: later attempts expire nothing
    wr(8'hf0, 32'h00000001);
    wr(8'hf0, 32'h00000002);
    rd(8'hf0, 32'h00000000);
    ev_src.send(3'h1, 3, 1);
    repeat (6) @(posedge clk_i);
    `CHK(n_r, 1)
    // both master timeouts at three ticks, masked first
    wr(8'h80, 32'h00030003);
    wr(8'hf8, 32'h00000000);
    wr(8'hf0, 32'h0000000c);
    ev_src.send(3'h6, 3, 4);
    for (int i = 0; i < 200 && (n_p < 1 || n_s < 1); i++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    `CHK(n_p, 1)
    `CHK(n_s, 1)
    `CHK(irq, 1'b0)
    wr(8'hf8, 32'h00000002);
    repeat (3) @(posedge clk_i);
    `CHK(irq, 1'b1)
    rd(8'hf4, 32'h00000006);
    repeat (3) @(posedge clk_i);
    `CHK(irq, 1'b0)
    // power state codes, then d3 to d0
    wr(8'he0, 32'hffffffff);
    rd(8'he0, 32'h00000003);
    wr(8'he0, 32'h00000001);
    rd(8'he0, 32'h00000003);
    wr(8'he0, 32'h00000002);
    rd(8'he0, 32'h00000003);
    wr(8'he0, 32'h00000000);
    repeat (4) @(posedge clk_i);
    `CHK(c_rst, 1'b1)
    repeat (10) @(posedge clk_i);
    `CHK(c_rst, 1'b0)
    rd(8'he0, 32'h00000000);
    rd(8'h78, 32'h01000000);
    rd(8'hb0, 32'h00000004);
    close_out();
  end
endmodule
